/* verilog/scm_pkg.sv */
package scm_pkg;

  // ==========================================================
  // Sizes
  localparam int NUM_DI      = 6;
  localparam int NUM_VI      = 4;
  localparam int NUM_VO      = 6;
  localparam int NUM_OBJ     = 8;
  localparam int NUM_CTRL    = 6;
  localparam int NUM_STAGE   = 8;
  localparam int NUM_LOGIC   = 8;
  localparam int NUM_RELAY   = 8;
  localparam int NUM_LED     = 5;

  // ==========================================================
  // Routed signal vector layout
  localparam int SRC_DI_POS    = 0;
  localparam int SRC_VI_POS    = SRC_DI_POS + NUM_DI;
  localparam int SRC_START_POS = SRC_VI_POS + NUM_VI;
  localparam int SRC_TRIP_POS  = SRC_START_POS + NUM_STAGE;
  localparam int SRC_LOGIC_POS = SRC_TRIP_POS + NUM_STAGE;
  localparam int SRC_OPEN_POS  = SRC_LOGIC_POS + NUM_LOGIC;
  localparam int SRC_CLOSE_POS = SRC_OPEN_POS + NUM_CTRL;
  localparam int SRC_FAIL_POS  = SRC_CLOSE_POS + NUM_CTRL;
  localparam int SRC_VO_POS    = SRC_FAIL_POS + 1;
  localparam int NUM_SRC       = SRC_VO_POS + NUM_VO;

  // Output matrix targets: relays, lamps, virtual outputs, recorder
  localparam int DST_RELAY_POS = 0;
  localparam int DST_LED_POS   = DST_RELAY_POS + NUM_RELAY;
  localparam int DST_VO_POS    = DST_LED_POS + NUM_LED;
  localparam int DST_DR_POS    = DST_VO_POS + NUM_VO;
  localparam int NUM_DST       = DST_DR_POS + 1;

  // Blocking sources: digital inputs, stage start/trip, logic
  localparam int NUM_BLK_SRC   = NUM_DI + 2 * NUM_STAGE + NUM_LOGIC;

  // ==========================================================
  // Time base
  localparam int CLK_HZ        = 20_000_000;
  localparam int TICK_MS       = 10;
  localparam int TICK_CYCLES   = CLK_HZ / 1000 * TICK_MS;
  localparam int TIME_W        = 16;
  localparam int MIN_TICKS     = 2;
  localparam int MAX_TICKS     = 60_000;
  localparam int SEL_W         = 5;
  localparam logic [SEL_W-1:0] SEL_NONE = 5'h1F;

  // Object positions
  typedef enum logic [1:0] {
    scm_pos_undef00_type = 2'h0,
    scm_pos_open_type    = 2'h1,
    scm_pos_close_type   = 2'h2,
    scm_pos_undef11_type = 2'h3
  } scm_pos_type;

  // ==========================================================
  function automatic logic scm_pick(input logic [31:0] vec,
                                    input logic [SEL_W-1:0] sel);
    scm_pick = (sel == SEL_NONE) ? 1'b0 : vec[sel];
  endfunction : scm_pick

  function automatic logic [TIME_W-1:0] scm_clamp(
      input logic [TIME_W-1:0] t);
    if (t < TIME_W'(MIN_TICKS))
      scm_clamp = TIME_W'(MIN_TICKS);
    else if (t > TIME_W'(MAX_TICKS))
      scm_clamp = TIME_W'(MAX_TICKS);
    else
      scm_clamp = t;
  endfunction : scm_clamp

endpackage : scm_pkg

/* verilog/scm_object.sv */
module scm_object
  import scm_pkg::*;
#(
  parameter bit CONTROLLABLE = 1'b1
) (
  // Clock and reset
  input  wire logic              clk,
  input  wire logic              resetn,
  input  wire logic              tick,
  // Feedback and settings
  input  wire logic              fb_open,
  input  wire logic              fb_close,
  input  wire logic              fb_ready,
  input  wire logic              ready_used,
  input  wire logic [TIME_W-1:0] pulse_len,
  input  wire logic [TIME_W-1:0] done_len,
  // Commands, single cycle
  input  wire logic              cmd_open,
  input  wire logic              cmd_close,
  // Results
  output scm_pos_type            pos,
  output logic                   open_pulse,
  output logic                   close_pulse,
  output logic                   failed,
  output logic                   undef_event
);

  typedef enum logic [1:0] {
    scm_idle_type, scm_drive_type, scm_wait_ready_type
  } scm_ost_type;

  scm_ost_type       st_r;
  logic              target_open_r;
  logic [TIME_W-1:0] cnt_r;
  logic              reached;

  assign pos     = scm_pos_type'({fb_close, fb_open});
  assign reached = target_open_r ? (pos == scm_pos_open_type)
                                 : (pos == scm_pos_close_type);

  // ==========================================================
  // Command sequencing and supervision
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      st_r          <= scm_idle_type;
      target_open_r <= 1'b0;
      cnt_r         <= '0;
      open_pulse    <= 1'b0;
      close_pulse   <= 1'b0;
      failed        <= 1'b0;
      undef_event   <= 1'b0;
    end else begin
      undef_event <= 1'b0;
      case (st_r)
        scm_idle_type: begin
          if (CONTROLLABLE && (cmd_open || cmd_close)) begin
            target_open_r <= cmd_open;
            open_pulse    <= cmd_open; // RL12
            close_pulse   <= !cmd_open; // RL12
            cnt_r         <= scm_clamp(pulse_len);
            failed        <= 1'b0;
            st_r          <= scm_drive_type;
          end else if (!CONTROLLABLE) begin
            // Status-only: timer runs while position is undefined
            if (pos == scm_pos_open_type || pos == scm_pos_close_type) begin
              cnt_r  <= scm_clamp(pulse_len);
              failed <= 1'b0;
            end else if (tick && cnt_r != '0) begin
              cnt_r <= cnt_r - 1'b1;
              if (cnt_r == TIME_W'(1)) begin
                failed      <= 1'b1; // RL17
                undef_event <= 1'b1; // RL17
              end
            end
          end
        end
        scm_drive_type: begin
          if (reached) begin
            open_pulse  <= 1'b0;
            close_pulse <= 1'b0;
            cnt_r       <= scm_clamp(done_len);
            st_r        <= ready_used ? scm_wait_ready_type
                                      : scm_idle_type; // RL16
          end else if (tick) begin
            if (cnt_r == TIME_W'(1)) begin
              open_pulse  <= 1'b0; // RL14
              close_pulse <= 1'b0; // RL14
              failed      <= 1'b1; // RL15
              undef_event <= 1'b1; // RL15
              st_r        <= scm_idle_type;
            end
            cnt_r <= cnt_r - 1'b1; // RL23
          end
        end
        scm_wait_ready_type: begin
          if (fb_ready) begin
            st_r <= scm_idle_type;
          end else if (tick) begin
            if (cnt_r == TIME_W'(1)) begin
              failed <= 1'b1; // RL16
              st_r   <= scm_idle_type;
            end
            cnt_r <= cnt_r - 1'b1;
          end
        end
        default: st_r <= scm_idle_type;
      endcase
    end
  end

  // ==========================================================
  property p_pulse_one_hot;
    @(posedge clk) disable iff (!resetn)
      !(open_pulse && close_pulse);
  endproperty
  a_pulse_one_hot: assert property (p_pulse_one_hot) // RL12
    else $error("open and close pulse together");

  property p_fail_ends_pulse;
    @(posedge clk) disable iff (!resetn)
      $rose(failed) && CONTROLLABLE && $past(st_r) == scm_drive_type
        |-> !open_pulse && !close_pulse && undef_event;
  endproperty
  a_fail_ends_pulse: assert property (p_fail_ends_pulse) // RL15
    else $error("failure without pulse end or event");

endmodule : scm_object

/* verilog/scm_control_matrix.sv */
// Behaviour
// [RL1] Four virtual inputs, six virtual outputs provided
// [RL2] Virtual input bits; shared event enable
// [RL3] Virtual inputs written by panel, bus, tool
// [RL4] Routing matrix from internal signals to targets
// [RL5] Non-latched outputs follow routed signal
// [RL6] Latched outputs hold until release
// [RL7] One common release clears all latches
// [RL8] Selectable input or parameter write releases
// [RL9] Blocking matrix inhibits protection stages
// [RL10] Eight objects; six controllable, two status
// [RL11] Select-execute and direct commands supported
// [RL12] Open/close pulses per commanded object
// [RL13] Position from feedback; 00, 11 undefined
// [RL14] Command pulse limited to maximum length
// [RL15] No new position: fail and event
// [RL16] Ready timeout, ignored without ready input
// [RL17] Status-only timeout sets fail and event
// [RL18] Remote/local inputs honoured by mode only
// [RL19] Command on rising edge of input
// [RL20] Driver holds control pulse 60 ms; here the pulse ends on reaching the position or after pulse_len ticks
// [RL21] Local mode panel, remote mode serial
// [RL22] Mode from panel or one input
// [RL23] Timers count clock ticks; reset clears
module scm_control_matrix
  import scm_pkg::*;
(
  // Clock and reset
  input  wire logic                         clk,
  input  wire logic                         resetn,
  // Raw signals
  input  wire logic [NUM_DI-1:0]            di,
  input  wire logic [NUM_STAGE-1:0]         stage_start,
  input  wire logic [NUM_STAGE-1:0]         stage_trip,
  input  wire logic [NUM_LOGIC-1:0]         logic_out,
  // Virtual input writes, one-cycle strobes
  input  wire logic [NUM_VI-1:0]            vi_panel_we,
  input  wire logic [NUM_VI-1:0]            vi_bus_we,
  input  wire logic [NUM_VI-1:0]            vi_tool_we,
  input  wire logic [NUM_VI-1:0]            vi_wdata,
  input  wire logic                         vi_events_en,
  // Matrices, row per target / per stage
  input  wire logic [NUM_DST*NUM_SRC-1:0]   out_map,
  input  wire logic [NUM_DST-1:0]           out_latched,
  input  wire logic [NUM_STAGE*NUM_BLK_SRC-1:0] blk_map,
  // Latch release
  input  wire logic [SEL_W-1:0]             release_di_sel,
  input  wire logic                         release_key,
  input  wire logic                         release_comm,
  input  wire logic                         release_param,
  // Local/remote
  input  wire logic                         lr_panel_remote,
  input  wire logic [SEL_W-1:0]             lr_di_sel,
  // Object settings
  input  wire logic [NUM_OBJ*SEL_W-1:0]     obj_open_sel,
  input  wire logic [NUM_OBJ*SEL_W-1:0]     obj_close_sel,
  input  wire logic [NUM_CTRL*SEL_W-1:0]    obj_ready_sel,
  input  wire logic [NUM_CTRL*SEL_W-1:0]    rem_open_sel,
  input  wire logic [NUM_CTRL*SEL_W-1:0]    rem_close_sel,
  input  wire logic [NUM_CTRL*SEL_W-1:0]    loc_open_sel,
  input  wire logic [NUM_CTRL*SEL_W-1:0]    loc_close_sel,
  input  wire logic [NUM_OBJ*TIME_W-1:0]    obj_pulse_len,
  input  wire logic [NUM_CTRL*TIME_W-1:0]   obj_done_len,
  // Panel / bus commands: select then execute, or direct
  input  wire logic                         panel_cmd,
  input  wire logic                         bus_cmd,
  input  wire logic [2:0]                   cmd_obj,
  input  wire logic                         cmd_open,
  input  wire logic                         cmd_select,
  input  wire logic                         cmd_execute,
  input  wire logic                         cmd_cancel,
  // Results
  output logic [NUM_VI-1:0]                 virtual_input,
  output logic                              vi_event,
  output logic [NUM_RELAY-1:0]              relay_out,
  output logic [NUM_LED-1:0]                led_out,
  output logic [NUM_VO-1:0]                 virtual_output,
  output logic                              disturbance_recorder_trigger,
  output logic [NUM_STAGE-1:0]              stage_block,
  output logic                              remote_mode,
  output logic                              cmd_accepted,
  output logic                              cmd_rejected,
  output logic [2*NUM_OBJ-1:0]              obj_state,
  output logic [NUM_CTRL-1:0]               obj_open_pulse,
  output logic [NUM_CTRL-1:0]               obj_close_pulse,
  output logic                              object_failure,
  output logic                              undef_event
);

  // ==========================================================
  // Time base
  logic [$clog2(TICK_CYCLES)-1:0] tick_cnt_r;
  logic                           tick;
  assign tick = (tick_cnt_r == '0);

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      tick_cnt_r <= '0;
    end else if (tick) begin
      tick_cnt_r <= ($clog2(TICK_CYCLES))'(TICK_CYCLES - 1); // RL23
    end else begin
      tick_cnt_r <= tick_cnt_r - 1'b1;
    end
  end

  // ==========================================================
  // Virtual inputs
  logic [NUM_VI-1:0] vi_nxt;
  always_comb begin
    vi_nxt = virtual_input;
    for (int i = 0; i < NUM_VI; i++) begin
      if (vi_panel_we[i] || vi_bus_we[i] || vi_tool_we[i]) begin // RL3
        vi_nxt[i] = vi_wdata[i];
      end
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      virtual_input <= '0;
      vi_event      <= 1'b0;
    end else begin
      virtual_input <= vi_nxt; // RL2
      vi_event      <= vi_events_en && (vi_nxt != virtual_input); // RL2
    end
  end

  // ==========================================================
  // Selectable source vector: DI, VI, VO for object feedback
  logic [31:0]          sel_vec;
  logic [NUM_OBJ-1:0]   obj_fail;
  logic [NUM_OBJ-1:0]   obj_undef;
  assign sel_vec = 32'({virtual_output, virtual_input, di}); // RL1

  // Local/remote mode
  always_comb begin
    if (lr_di_sel != SEL_NONE)
      remote_mode = !scm_pick(sel_vec, lr_di_sel); // RL22
    else
      remote_mode = lr_panel_remote; // RL22
  end

  // ==========================================================
  // Control inputs: edge detect on selected input
  logic [NUM_CTRL-1:0] ctl_open_lvl;
  logic [NUM_CTRL-1:0] ctl_close_lvl;
  logic [NUM_CTRL-1:0] ctl_open_r;
  logic [NUM_CTRL-1:0] ctl_close_r;

  always_comb begin
    for (int i = 0; i < NUM_CTRL; i++) begin
      ctl_open_lvl[i]  = remote_mode
        ? scm_pick(sel_vec, rem_open_sel[i*SEL_W +: SEL_W])
        : scm_pick(sel_vec, loc_open_sel[i*SEL_W +: SEL_W]); // RL18
      ctl_close_lvl[i] = remote_mode
        ? scm_pick(sel_vec, rem_close_sel[i*SEL_W +: SEL_W])
        : scm_pick(sel_vec, loc_close_sel[i*SEL_W +: SEL_W]); // RL18
    end
  end

  // A mode change may fake an edge when only the newly selected input is high;
  // the cost of gating it is a lost genuine edge at that moment.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      ctl_open_r  <= '0;
      ctl_close_r <= '0;
    end else begin
      ctl_open_r  <= ctl_open_lvl;
      ctl_close_r <= ctl_close_lvl;
    end
  end

  // ==========================================================
  // Panel and bus commands, gated by mode
  logic       sel_valid_r;
  logic [2:0] sel_obj_r;
  logic       sel_open_r;
  logic       src_ok;
  logic       go;
  logic       go_open;
  logic       sel_ok;
  logic       can_ok;
  assign src_ok = remote_mode ? bus_cmd : panel_cmd; // RL21
  // A cancel strobe must never be taken as a direct command
  assign go = src_ok && cmd_obj < 3'(NUM_CTRL) && (
              (!cmd_select && !cmd_execute && !cmd_cancel) ||
              (cmd_execute && sel_valid_r && sel_obj_r == cmd_obj
               && sel_open_r == cmd_open)); // RL11
  assign go_open = cmd_open;
  assign sel_ok  = src_ok && cmd_select && cmd_obj < 3'(NUM_CTRL);
  assign can_ok  = src_ok && cmd_cancel;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      sel_valid_r  <= 1'b0;
      sel_obj_r    <= 3'h0;
      sel_open_r   <= 1'b0;
      cmd_accepted <= 1'b0;
      cmd_rejected <= 1'b0;
    end else begin
      cmd_accepted <= go || sel_ok || can_ok;
      cmd_rejected <= (panel_cmd || bus_cmd) && !go && !sel_ok
                      && !can_ok; // RL21
      if (sel_ok) begin
        sel_valid_r <= 1'b1; // RL11
        sel_obj_r   <= cmd_obj;
        sel_open_r  <= cmd_open;
      end else if (go || can_ok) begin
        sel_valid_r <= 1'b0;
      end
    end
  end

  // ==========================================================
  // Objects
  for (genvar g = 0; g < NUM_OBJ; g++) begin : g_obj
    localparam bit CTRL = (g < NUM_CTRL); // RL10
    logic        c_open;
    logic        c_close;
    logic        rdy;
    logic        rdy_used;
    logic        o_pulse;
    logic        c_pulse;
    scm_pos_type p;
    if (CTRL) begin : g_c
      logic dir_hit;
      assign dir_hit  = go && cmd_obj == 3'(g);
      assign c_open   = (ctl_open_lvl[g] && !ctl_open_r[g])
                        || (dir_hit && go_open); // RL19
      assign c_close  = (ctl_close_lvl[g] && !ctl_close_r[g])
                        || (dir_hit && !go_open); // RL19
      assign rdy_used = obj_ready_sel[g*SEL_W +: SEL_W] != SEL_NONE;
      assign rdy      = scm_pick(sel_vec, obj_ready_sel[g*SEL_W +: SEL_W]);
      assign obj_open_pulse[g]  = o_pulse;
      assign obj_close_pulse[g] = c_pulse;
    end else begin : g_s
      assign c_open   = 1'b0;
      assign c_close  = 1'b0;
      assign rdy_used = 1'b0;
      assign rdy      = 1'b0;
    end
    scm_object #(.CONTROLLABLE(CTRL)) u_obj (
      .clk        (clk),
      .resetn     (resetn),
      .tick       (tick),
      .fb_open    (scm_pick(sel_vec, obj_open_sel[g*SEL_W +: SEL_W])),
      .fb_close   (scm_pick(sel_vec, obj_close_sel[g*SEL_W +: SEL_W])),
      .fb_ready   (rdy),
      .ready_used (rdy_used),
      .pulse_len  (obj_pulse_len[g*TIME_W +: TIME_W]),
      .done_len   (CTRL ? obj_done_len[(g % NUM_CTRL)*TIME_W +: TIME_W]
                        : TIME_W'(0)),
      .cmd_open   (c_open),
      .cmd_close  (c_close),
      .pos        (p),
      .open_pulse (o_pulse),
      .close_pulse(c_pulse),
      .failed     (obj_fail[g]),
      .undef_event(obj_undef[g])
    );
    assign obj_state[2*g +: 2] = p; // RL13
  end

  assign object_failure = |obj_fail; // RL15
  assign undef_event    = |obj_undef;

  // ==========================================================
  // Output matrix with latching
  logic [NUM_SRC-1:0] src_vec;
  logic [NUM_DST-1:0] routed;
  logic [NUM_DST-1:0] latch_r;
  logic [NUM_DST-1:0] dst_val;
  logic               release_all;

  assign src_vec = {virtual_output, object_failure, obj_close_pulse,
                    obj_open_pulse, logic_out, stage_trip, stage_start,
                    virtual_input, di};

  always_comb begin
    for (int t = 0; t < NUM_DST; t++) begin
      routed[t] = |(out_map[t*NUM_SRC +: NUM_SRC] & src_vec); // RL4
    end
  end

  assign release_all = release_key || release_comm || release_param
                       || scm_pick(32'(di), release_di_sel); // RL7 RL8

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      latch_r <= '0; // RL23
    end else begin
      for (int t = 0; t < NUM_DST; t++) begin
        if (routed[t])
          latch_r[t] <= out_latched[t]; // RL6
        else if (release_all)
          latch_r[t] <= 1'b0; // RL7
      end
    end
  end

  assign dst_val = routed | (latch_r & out_latched); // RL5 RL6

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      relay_out                    <= '0;
      led_out                      <= '0;
      virtual_output               <= '0;
      disturbance_recorder_trigger <= 1'b0;
    end else begin
      relay_out      <= dst_val[DST_RELAY_POS +: NUM_RELAY];
      led_out        <= dst_val[DST_LED_POS +: NUM_LED];
      virtual_output <= dst_val[DST_VO_POS +: NUM_VO]; // RL1
      disturbance_recorder_trigger <= dst_val[DST_DR_POS];
    end
  end

  // ==========================================================
  // Blocking matrix
  logic [NUM_BLK_SRC-1:0] blk_src;
  assign blk_src = {logic_out, stage_trip, stage_start, di};
  always_comb begin
    for (int s = 0; s < NUM_STAGE; s++) begin
      stage_block[s] = |(blk_map[s*NUM_BLK_SRC +: NUM_BLK_SRC]
                         & blk_src); // RL9
    end
  end

  // ==========================================================
  property p_nonlatched_follow;
    @(posedge clk) disable iff (!resetn)
      !out_latched[0] |=> relay_out[0] == $past(routed[0]);
  endproperty
  a_nonlatched_follow: assert property (p_nonlatched_follow) // RL5
    else $error("non-latched relay does not follow");

  property p_latch_hold;
    @(posedge clk) disable iff (!resetn)
      out_latched[1] && latch_r[1] && !release_all && !routed[1]
        |=> latch_r[1] && relay_out[1];
  endproperty
  a_latch_hold: assert property (p_latch_hold) // RL6
    else $error("latched relay dropped without release");

  property p_release;
    @(posedge clk) disable iff (!resetn)
      release_all && !routed[1] ##1 !routed[1] |=> !relay_out[1];
  endproperty
  a_release: assert property (p_release) // RL7
    else $error("release did not clear latch");

  property p_vi_write;
    @(posedge clk) disable iff (!resetn)
      vi_bus_we[0] |=> virtual_input[0] == $past(vi_wdata[0]);
  endproperty
  a_vi_write: assert property (p_vi_write) // RL3
    else $error("virtual input write lost");

  property p_vi_event;
    @(posedge clk) disable iff (!resetn)
      !vi_events_en |=> !vi_event;
  endproperty
  a_vi_event: assert property (p_vi_event) // RL2
    else $error("event while events disabled");

  sequence s_rise_open0;
    !ctl_open_lvl[0] ##1 ctl_open_lvl[0];
  endsequence
  property p_edge_pulse;
    @(posedge clk) disable iff (!resetn)
      s_rise_open0 ##0 (obj_state[1:0] != 2'h1) && !obj_open_pulse[0]
        && !obj_close_pulse[0] && obj_ready_sel[SEL_W-1:0] == SEL_NONE
        |=> obj_open_pulse[0];
  endproperty
  a_edge_pulse: assert property (p_edge_pulse) // RL19
    else $error("rising edge did not command object");

  property p_mode_gate;
    @(posedge clk) disable iff (!resetn)
      panel_cmd && !bus_cmd && remote_mode |=> !cmd_accepted;
  endproperty
  a_mode_gate: assert property (p_mode_gate) // RL21
    else $error("panel command accepted in remote mode");

  property p_block;
    @(posedge clk) disable iff (!resetn)
      blk_map[2] && di[2] |-> stage_block[0];
  endproperty
  a_block: assert property (p_block) // RL9
    else $error("blocking not applied");

endmodule : scm_control_matrix

/* tb/scm_gear_model.sv */
module scm_gear_model (
  // Clock and reset
  input  wire logic clk,
  input  wire logic resetn,
  // Drive pulses in, contacts out
  input  wire logic open_pulse,
  input  wire logic close_pulse,
  output logic      fb_open,
  output logic      fb_close
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [2:0] cnt_r;
  logic       dir_r;
  // ====
  // Travel: both contacts drop, so the relay sees 00 on the way
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      cnt_r <= 3'h0;
      dir_r <= 1'b1;
    end else if (cnt_r != 3'h0) begin
      cnt_r <= cnt_r - 3'h1;
    end else if ((open_pulse && !dir_r) || (close_pulse && dir_r)) begin
      cnt_r <= 3'h5;
      dir_r <= !dir_r;
    end
  end
  assign fb_open  = (cnt_r == 3'h0) && dir_r;
  assign fb_close = (cnt_r == 3'h0) && !dir_r;
endmodule : scm_gear_model

/* tb/testbench.sv */
module testbench
  import scm_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ns;
  logic                             clk, resetn, fo, fc, acc, rej;
  logic                             bcmd, pcmd, copen, csel, cexe;
  logic [2:0]                       rel;
  logic [3:0]                       di_lo, pwe, bwe, twe, vwd, vi_o;
  logic [7:0]                       rly, blk;
  logic [NUM_DST*NUM_SRC-1:0]       omap;
  logic [NUM_STAGE*NUM_BLK_SRC-1:0] bmap;
  logic [2*NUM_OBJ-1:0]             ost;
  logic [NUM_CTRL-1:0]              opl, cpl;
  logic                             ven, lpr, ccan, vev, rmd, drt;
  logic [NUM_LED-1:0]               led;
  logic [NUM_VO-1:0]                vo;
  logic [NUM_DST-1:0]               olat;
  int                               n_errors, n_tests;
  // ====
  // Device and switchgear
  scm_control_matrix dut (.clk(clk), .resetn(resetn),
    .di({fc, fo, di_lo}), .stage_start('0), .stage_trip('0),
    .logic_out('0), .vi_panel_we(pwe), .vi_bus_we(bwe), .vi_tool_we(twe),
    .vi_wdata(vwd), .vi_events_en(ven), .out_map(omap),
    .out_latched(olat), .blk_map(bmap), .release_di_sel(5'h03),
    .release_key(rel[2]), .release_comm(rel[1]), .release_param(rel[0]),
    .lr_panel_remote(lpr), .lr_di_sel(SEL_NONE),
    .obj_open_sel({{7{SEL_NONE}}, 5'h4}),
    .obj_close_sel({{7{SEL_NONE}}, 5'h5}), .obj_ready_sel({6{SEL_NONE}}),
    .rem_open_sel({6{SEL_NONE}}), .rem_close_sel({6{SEL_NONE}}),
    .loc_open_sel({{5{SEL_NONE}}, 5'h7}),
    .loc_close_sel({{5{SEL_NONE}}, 5'h6}),
    .obj_pulse_len({8{16'h0064}}), .obj_done_len({6{16'h0064}}),
    .panel_cmd(pcmd), .bus_cmd(bcmd), .cmd_obj(3'h0), .cmd_open(copen),
    .cmd_select(csel), .cmd_execute(cexe), .cmd_cancel(ccan),
    .virtual_input(vi_o), .vi_event(vev), .relay_out(rly), .led_out(led),
    .virtual_output(vo), .disturbance_recorder_trigger(drt),
    .stage_block(blk), .remote_mode(rmd), .cmd_accepted(acc),
    .cmd_rejected(rej), .obj_state(ost), .obj_open_pulse(opl),
    .obj_close_pulse(cpl), .object_failure(), .undef_event());
  scm_gear_model gear (.clk(clk), .resetn(resetn), .open_pulse(opl[0]),
    .close_pulse(cpl[0]), .fb_open(fo), .fb_close(fc));
  // ====
  // Helpers
  task automatic chk(input logic [7:0] s, input logic [7:0] e);
    n_tests++;
    if (s !== e) begin
      n_errors++;
      $display("BAD t=%0t seen %h want %h", $time, s, e);
    end
  endtask : chk
  // Strobes last one cycle; outputs are read at the falling edge
  task automatic nx(input int n);
    repeat (n) begin
      @(posedge clk);
      {pwe, bwe, twe, rel, bcmd, pcmd, csel, cexe, ccan} <= '0;
    end
    @(negedge clk);
  endtask : nx
  task automatic report_and_stop();
    $display("checks %0d, errors %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : report_and_stop
  // ====
  // Tests
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  initial begin
    #200000;
    n_errors++;
    report_and_stop();
  end
  initial begin
    {resetn, di_lo, pwe, bwe, twe, vwd, rel, ven, ccan} = '0;
    lpr = 1'b1;
    olat = 20'h0_0002;
    {bcmd, pcmd, copen, csel, cexe, n_errors, n_tests} = '0;
    omap = '0;
    omap[SRC_DI_POS] = 1'b1;
    omap[NUM_SRC + SRC_DI_POS + 1] = 1'b1;
    omap[DST_LED_POS * NUM_SRC + SRC_DI_POS + 1] = 1'b1;
    omap[DST_VO_POS * NUM_SRC + SRC_DI_POS + 2] = 1'b1;
    omap[DST_DR_POS * NUM_SRC + SRC_DI_POS] = 1'b1;
    bmap = '0;
    bmap[2] = 1'b1;
    repeat (2) @(posedge clk);
    resetn <= 1'b1;
    nx(1);
    for (int i = 0; i < 3; i++) begin
      @(posedge clk);
      vwd <= 4'h5 << i;
      ven <= (i != 2);
      {pwe, bwe, twe} <= 12'hF00 >> (4 * i);
      nx(1);
      chk(vi_o, vwd);
      chk(vev, i != 2);
    end
    $display("virtual input test done");
    @(posedge clk);
    di_lo <= 4'h7;
    nx(2);
    chk(rly, 8'h03);
    chk(blk, 8'h01);
    chk({drt, vo, led[0]}, 8'h83);
    for (int i = 0; i < 4; i++) begin
      @(posedge clk);
      di_lo <= 4'h0;
      nx(2);
      chk(rly, 8'h02);
      chk({drt, vo, led[0]}, 8'h00);
      @(posedge clk);
      rel <= 3'h1 << i;
      di_lo <= {i == 3, 3'h0};
      nx(2);
      chk(rly, 8'h00);
      @(posedge clk);
      di_lo <= 4'h3;
      nx(2);
    end
    $display("matrix test done");
    @(posedge clk);
    {bcmd, copen} <= 2'b10;
    nx(1);
    chk(cpl[0], 1'b1);
    chk(acc, 1'b1);
    nx(3);
    chk(ost[1:0], 2'b00);
    nx(8);
    chk(ost[1:0], 2'b10);
    chk(cpl[0], 1'b0);
    @(posedge clk);
    {bcmd, cexe, copen} <= 3'b111;
    nx(1);
    chk(rej, 1'b1);
    @(posedge clk);
    {bcmd, csel} <= 2'b11;
    nx(1);
    @(posedge clk);
    {bcmd, cexe} <= 2'b11;
    nx(1);
    chk(opl[0], 1'b1);
    nx(10);
    chk(ost[1:0], 2'b01);
    @(posedge clk);
    {pcmd, copen} <= 2'b10;
    nx(1);
    chk(rej, 1'b1);
    chk(cpl[0], 1'b0);
    // Local mode: bus refused, local control inputs take over
    @(posedge clk);
    lpr <= 1'b0;
    {bcmd, copen} <= 2'b11;
    {pwe, vwd} <= 8'h11;
    nx(1);
    chk(rmd, 1'b0);
    chk(rej, 1'b1);
    nx(1);
    chk(cpl[0], 1'b1);
    nx(10);
    chk(ost[1:0], 2'b10);
    @(posedge clk);
    {pwe, vwd} <= 8'h22;
    nx(2);
    chk(opl[0], 1'b1);
    nx(8);
    @(posedge clk);
    {pcmd, csel} <= 2'b11;
    nx(1);
    @(posedge clk);
    {pcmd, ccan} <= 2'b11;
    nx(1);
    chk(opl[0], 1'b0);
    @(posedge clk);
    {pcmd, cexe} <= 2'b11;
    nx(1);
    chk(rej, 1'b1);
    $display("object test done");
    report_and_stop();
  end
endmodule : testbench
